// >>> logic/cpu_control_and_wide_arith_exec.sv
// Sequencer for control instructions, interrupt modes and 16-bit arithmetic
// Functional notes
// - Opcode 00 idles four T states, nothing changes
// - Opcode 76 suspends until interrupt or reset
// - Suspended, keep idle fetches and refresh strobes
// - F3 clears both enable flops in four T
// - Disabled: ignore interrupt request until enable
// - FB sets both interrupt enable flops
// - No acceptance during enable or next instruction
// - ED 46 picks mode zero; peripheral supplies instruction
// - Mode zero: first byte on acknowledge, rest normal
// - ED 56 picks mode one: restart at 0038
// - ED 5E picks vectored mode, base forms high
// - Vectored: read table entry, call its address
// - Add selected pair to accumulator pair, 11 T
// - Add with carry into accumulator pair, 15 T
// - Add with carry sets all six flags
// - Subtract pair and carry from accumulator, 15 T
// - Subtract with borrow flags, subtract flag set
`default_nettype none
module cpu_control_and_wide_arith_exec
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // System bus
    output var  logic [15:0] mem_addr,
    output var  logic        mem_read,
    output var  logic        mem_write,
    output var  logic [7:0]  mem_wdata,
    output var  logic        irq_ack,
    output var  logic        refresh_strobe,
    input  wire logic        mem_valid,
    input  wire logic [7:0]  mem_rdata,
    // Interrupt request pin
    input  wire logic        maskable_irq_req,
    // Register preload
    input  wire logic        load_en,
    input  wire logic [1:0]  load_sel,
    input  wire logic [15:0] load_data,
    input  wire logic        base_load_en,
    input  wire logic [7:0]  base_load_data,
    // Visible state
    output var  logic [15:0] program_counter,
    output var  logic [15:0] pair_one,
    output var  logic [15:0] pair_two,
    output var  logic [15:0] accum_pair,
    output var  logic [15:0] stack_pointer,
    output var  logic [7:0]  vector_base_reg,
    output var  logic        sign_flag,
    output var  logic        zero_flag,
    output var  logic        half_carry_flag,
    output var  logic        parity_overflow_flag,
    output var  logic        subtract_flag,
    output var  logic        carry_flag,
    output var  logic        int_enable_ff_main,
    output var  logic        int_enable_ff_shadow,
    output var  logic [1:0]  irq_mode,
    output var  logic        suspended
);
    typedef struct packed {
        exec_state_e st;
        logic        halted;
        logic        prefix;
        logic        ei_block;
        logic [7:0]  opcode;
        logic [3:0]  tcnt;
        logic [3:0]  tlen;
        logic [15:0] pc;
        logic [15:0] p_one;
        logic [15:0] p_two;
        logic [15:0] p_acc;
        logic [15:0] sp;
        logic [7:0]  vbase;
        logic [7:0]  vec;
        logic [7:0]  tmp_lo;
        logic        f_s;
        logic        f_z;
        logic        f_h;
        logic        f_pv;
        logic        f_n;
        logic        f_c;
        logic        iff_main;
        logic        iff_shadow;
        logic [1:0]  mode;
        logic        irq_s1;
        logic        irq_s2;
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
        logic        iack;
        logic        refresh;
    } exec_s;

    exec_s       q;
    exec_s       d;
    logic [1:0]  rst_pipe;
    logic        rst_sync_n;
    logic        done;
    logic        is_add;
    logic        is_adc;
    logic        is_sbc;
    alu16_if     alu ();

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic pair_op(input logic [7:0] op, input logic [7:0] base);
        pair_op = (op & PAIR_MASK) == base;
    endfunction

    function automatic logic [3:0] instr_len(input logic pfx, input logic [7:0] op);
        if (!pfx) begin
            instr_len = pair_op(op, OP_ADD_BASE) ? T_ADD16 : T_ONE_M;
        end else begin
            instr_len = (pair_op(op, OP_ADC_BASE) || pair_op(op, OP_SBC_BASE)) ?
                        T_EXT16_TAIL : T_MODE_TAIL;
        end
    endfunction

    function automatic logic [15:0] pair_value(input exec_s s, input logic [1:0] code);
        case (code)
            PAIR_ONE:   pair_value = s.p_one;
            PAIR_TWO:   pair_value = s.p_two;
            PAIR_ACCUM: pair_value = s.p_acc;
            default:    pair_value = s.sp;
        endcase
    endfunction

    // ****************************************
    // Reset release
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ****************************************
    // Adder hookup
    // ****************************************
    assign is_add        = !q.prefix && pair_op(q.opcode, OP_ADD_BASE);
    assign is_adc        = q.prefix && pair_op(q.opcode, OP_ADC_BASE);
    assign is_sbc        = q.prefix && pair_op(q.opcode, OP_SBC_BASE);
    assign alu.lhs       = q.p_acc;
    assign alu.rhs       = pair_value(q, q.opcode[PAIR_LSB +: 2]);
    assign alu.carry_in  = (is_adc || is_sbc) && q.f_c;
    assign alu.subtract  = is_sbc;

    alu16 adder (.bus(alu));

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d         = q;
        done      = 1'b0;
        d.irq_s1  = maskable_irq_req;
        d.irq_s2  = q.irq_s1;
        d.refresh = 1'b0;
        if (load_en) begin
            case (load_sel)
                PAIR_ONE:   d.p_one = load_data;
                PAIR_TWO:   d.p_two = load_data;
                PAIR_ACCUM: d.p_acc = load_data;
                default:    d.sp    = load_data;
            endcase
        end
        if (base_load_en) begin
            d.vbase = base_load_data;
        end
        case (q.st)
            S_START: begin
                d.st = S_FETCH;
            end
            S_FETCH, S_IACK: begin
                if (mem_valid) begin
                    if (q.st == S_IACK && q.mode != IRQ_MODE_0) begin
                        d.vec = mem_rdata;
                        d.st  = S_PUSH_HI;
                    end else begin
                        // Suspended fetches run as idle cycles; the byte is dropped
                        d.opcode  = q.halted ? OP_IDLE : mem_rdata;
                        d.tlen    = instr_len(q.prefix, d.opcode);
                        d.tcnt    = 4'h1;
                        d.st      = S_EXEC;
                        d.refresh = 1'b1;
                        if (q.st == S_FETCH && !q.halted) begin
                            d.pc = q.pc + 16'h0001;
                        end
                    end
                end
            end
            S_EXEC: begin
                if (q.tcnt == q.tlen - 4'h1) begin
                    done   = 1'b1;
                    d.st   = S_FETCH;
                    d.prefix = 1'b0;
                    if (!q.prefix) begin
                        case (q.opcode)
                            OP_IDLE: begin
                            end
                            OP_SUSPEND: d.halted = 1'b1;
                            OP_IRQ_OFF: begin
                                d.iff_main   = 1'b0;
                                d.iff_shadow = 1'b0;
                            end
                            OP_IRQ_ON: begin
                                d.iff_main   = 1'b1;
                                d.iff_shadow = 1'b1;
                            end
                            OP_PREFIX: d.prefix = 1'b1;
                            default: begin
                                if (is_add) begin
                                    d.p_acc = alu.result;
                                    d.f_h   = alu.half;
                                    d.f_c   = alu.carry;
                                    d.f_n   = 1'b0;
                                end
                            end
                        endcase
                    end else begin
                        case (q.opcode)
                            OP_MODE0: d.mode = IRQ_MODE_0;
                            OP_MODE1: d.mode = IRQ_MODE_1;
                            OP_MODE2: d.mode = IRQ_MODE_2;
                            default: begin
                                if (is_adc || is_sbc) begin
                                    d.p_acc = alu.result;
                                    d.f_s   = alu.result[15];
                                    d.f_z   = alu.result == RST_WORD;
                                    d.f_h   = alu.half;
                                    d.f_pv  = alu.overflow;
                                    d.f_n   = is_sbc;
                                    d.f_c   = alu.carry;
                                end
                            end
                        endcase
                    end
                    // Enable shadow spans the whole next instruction, prefix included
                    if (!d.prefix) begin
                        d.ei_block = !q.prefix && q.opcode == OP_IRQ_ON;
                        // Shadow ends with the next instruction: acceptance allowed at its end
                        if (q.irq_s2 && d.iff_main && !d.ei_block) begin
                            d.st         = S_IACK;
                            d.halted     = 1'b0;
                            d.iff_main   = 1'b0;
                            d.iff_shadow = 1'b0;
                        end
                    end
                end else begin
                    d.tcnt = q.tcnt + 4'h1;
                end
            end
            S_PUSH_HI: begin
                if (mem_valid) begin
                    d.st = S_PUSH_LO;
                end
            end
            S_PUSH_LO: begin
                if (mem_valid) begin
                    d.sp = q.sp - 16'h0002;
                    if (q.mode == IRQ_MODE_1) begin
                        d.pc = MODE1_TARGET;
                        d.st = S_FETCH;
                    end else begin
                        d.st = S_VEC_LO;
                    end
                end
            end
            S_VEC_LO: begin
                if (mem_valid) begin
                    d.tmp_lo = mem_rdata;
                    d.st     = S_VEC_HI;
                end
            end
            S_VEC_HI: begin
                if (mem_valid) begin
                    d.pc = {mem_rdata, q.tmp_lo};
                    d.st = S_FETCH;
                end
            end
            default: begin
                d.st = S_FETCH;
            end
        endcase
        // Bus request follows the state being entered
        d.rd   = 1'b0;
        d.wr   = 1'b0;
        d.iack = 1'b0;
        case (d.st)
            S_FETCH: begin
                d.rd   = 1'b1;
                d.addr = d.pc;
            end
            S_IACK: begin
                d.rd   = 1'b1;
                d.iack = 1'b1;
            end
            S_PUSH_HI: begin
                d.wr    = 1'b1;
                d.addr  = d.sp - 16'h0001;
                d.wdata = d.pc[15:8];
            end
            S_PUSH_LO: begin
                d.wr    = 1'b1;
                d.addr  = d.sp - 16'h0002;
                d.wdata = d.pc[7:0];
            end
            S_VEC_LO: begin
                d.rd   = 1'b1;
                d.addr = {d.vbase, d.vec};
            end
            S_VEC_HI: begin
                d.rd   = 1'b1;
                d.addr = {d.vbase, d.vec} + 16'h0001;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign mem_addr             = q.addr;
    assign mem_read             = q.rd;
    assign mem_write            = q.wr;
    assign mem_wdata            = q.wdata;
    assign irq_ack              = q.iack;
    assign refresh_strobe       = q.refresh;
    assign program_counter      = q.pc;
    assign pair_one             = q.p_one;
    assign pair_two             = q.p_two;
    assign accum_pair           = q.p_acc;
    assign stack_pointer        = q.sp;
    assign vector_base_reg      = q.vbase;
    assign sign_flag            = q.f_s;
    assign zero_flag            = q.f_z;
    assign half_carry_flag      = q.f_h;
    assign parity_overflow_flag = q.f_pv;
    assign subtract_flag        = q.f_n;
    assign carry_flag           = q.f_c;
    assign int_enable_ff_main   = q.iff_main;
    assign int_enable_ff_shadow = q.iff_shadow;
    assign irq_mode             = q.mode;
    assign suspended            = q.halted;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    sequence s_di_fetched;
        q.st == S_FETCH && mem_valid && !q.halted && !q.prefix && mem_rdata == OP_IRQ_OFF;
    endsequence

    sequence s_iffs_cleared;
        !q.iff_main && !q.iff_shadow;
    endsequence

    chk_idle_no_change: assert property (done && !q.prefix && q.opcode == OP_IDLE &&
        !load_en && d.st != S_IACK |=>
        q.p_acc == $past(q.p_acc) && q.f_c == $past(q.f_c) && q.iff_main == $past(q.iff_main))
        else $error("idle instruction changed state");
    chk_halt_holds: assert property (q.halted |=> q.halted || q.st == S_IACK)
        else $error("suspend left without interrupt");
    chk_halt_refresh: assert property (q.halted && q.st == S_FETCH && mem_valid |=>
        q.refresh ##3 q.st == S_FETCH || q.st == S_IACK)
        else $error("suspended fetch missed refresh or length");
    chk_di_timing: assert property (s_di_fetched |-> ##4 s_iffs_cleared)
        else $error("disable not done after four T states");
    chk_off_ignores: assert property (!q.iff_main && q.st != S_IACK |=> q.st != S_IACK)
        else $error("interrupt taken while disabled");
    chk_ei_sets: assert property (done && !q.prefix && q.opcode == OP_IRQ_ON |=>
        q.iff_main && q.iff_shadow)
        else $error("enable did not set both flops");
    chk_ei_shadow: assert property (done && !q.prefix && q.opcode == OP_IRQ_ON |=>
        q.st != S_IACK && q.ei_block)
        else $error("interrupt accepted inside enable shadow");
    chk_mode_select: assert property (done && q.prefix && q.opcode == OP_MODE2 |=>
        q.mode == IRQ_MODE_2)
        else $error("vectored mode not selected");
    chk_mode1_target: assert property (q.st == S_PUSH_LO && mem_valid && q.mode == IRQ_MODE_1
        |=> q.pc == MODE1_TARGET && q.st == S_FETCH)
        else $error("mode one restart address wrong");
    chk_add_result: assert property (done && is_add |=>
        q.p_acc == 16'($past(alu.lhs) + $past(alu.rhs)) && !q.f_n &&
        q.f_s == $past(q.f_s) && q.f_z == $past(q.f_z))
        else $error("wide add wrong");
    chk_sbc_flags: assert property (done && is_sbc |=>
        q.f_n && q.f_z == (q.p_acc == RST_WORD) && q.f_s == q.p_acc[15])
        else $error("subtract with borrow flags wrong");
endmodule
`default_nettype wire

// >>> logic/exec_pkg.sv
// Shared constants and types for the control and wide arithmetic execution unit
`default_nettype none
package exec_pkg;
    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_IDLE       = 8'h00;
    localparam logic [7:0] OP_SUSPEND    = 8'h76;
    localparam logic [7:0] OP_IRQ_OFF    = 8'hF3;
    localparam logic [7:0] OP_IRQ_ON     = 8'hFB;
    localparam logic [7:0] OP_PREFIX     = 8'hED;
    localparam logic [7:0] OP_MODE0      = 8'h46;
    localparam logic [7:0] OP_MODE1      = 8'h56;
    localparam logic [7:0] OP_MODE2      = 8'h5E;
    localparam logic [7:0] OP_ADD_BASE   = 8'h09;
    localparam logic [7:0] OP_ADC_BASE   = 8'h4A;
    localparam logic [7:0] OP_SBC_BASE   = 8'h42;
    localparam logic [7:0] PAIR_MASK     = 8'hCF;
    localparam int         PAIR_LSB      = 4;

    // ****************************************
    // Pair select codes and interrupt modes
    // ****************************************
    localparam logic [1:0] PAIR_ONE      = 2'h0;
    localparam logic [1:0] PAIR_TWO      = 2'h1;
    localparam logic [1:0] PAIR_ACCUM    = 2'h2;
    localparam logic [1:0] PAIR_STACK    = 2'h3;
    localparam logic [1:0] IRQ_MODE_0    = 2'h0;
    localparam logic [1:0] IRQ_MODE_1    = 2'h1;
    localparam logic [1:0] IRQ_MODE_2    = 2'h2;
    localparam logic [15:0] MODE1_TARGET = 16'h0038;

    // ****************************************
    // Timing in T states, one clock each
    // ****************************************
    localparam logic [3:0] T_ONE_M       = 4'h4;
    localparam logic [3:0] T_ADD16       = 4'hB;
    localparam logic [3:0] T_EXT16_TAIL  = 4'hB;
    localparam logic [3:0] T_MODE_TAIL   = 4'h4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;

    typedef enum logic [2:0] {
        S_START, S_FETCH, S_EXEC, S_IACK, S_PUSH_HI, S_PUSH_LO, S_VEC_LO, S_VEC_HI
    } exec_state_e;
endpackage
`default_nettype wire

// >>> logic/alu16_if.sv
// Operand and result bundle between the sequencer and the 16-bit adder
`default_nettype none
interface alu16_if;
    logic [15:0] lhs;
    logic [15:0] rhs;
    logic        carry_in;
    logic        subtract;
    logic [15:0] result;
    logic        half;
    logic        carry;
    logic        overflow;
    modport seq  (output lhs, rhs, carry_in, subtract, input result, half, carry, overflow);
    modport unit (input lhs, rhs, carry_in, subtract, output result, half, carry, overflow);
endinterface
`default_nettype wire

// >>> logic/alu16.sv
// 16-bit adder and subtracter with half carry and overflow
`default_nettype none
module alu16
    import exec_pkg::*;
(
    // Operands and results
    alu16_if.unit  bus
);
    logic [16:0] full;
    logic [12:0] low;
    logic [15:0] rhs_eff;

    // ****************************************
    // Arithmetic
    // ****************************************
    always_comb begin
        rhs_eff = bus.subtract ? ~bus.rhs : bus.rhs;
        if (bus.subtract) begin
            // Borrow taken as inverted carry of a + ~b + ~cin
            full = {1'b0, bus.lhs} + {1'b0, rhs_eff} + {16'h0000, ~bus.carry_in};
            low  = {1'b0, bus.lhs[11:0]} + {1'b0, rhs_eff[11:0]} + {12'h000, ~bus.carry_in};
            bus.carry = ~full[16];
            bus.half  = ~low[12];
        end else begin
            full = {1'b0, bus.lhs} + {1'b0, rhs_eff} + {16'h0000, bus.carry_in};
            low  = {1'b0, bus.lhs[11:0]} + {1'b0, rhs_eff[11:0]} + {12'h000, bus.carry_in};
            bus.carry = full[16];
            bus.half  = low[12];
        end
        bus.result   = full[15:0];
        bus.overflow = (bus.lhs[15] == rhs_eff[15]) && (full[15] != bus.lhs[15]);
    end
endmodule
`default_nettype wire

// >>> tb/bus_mem_model.sv
// Memory and interrupting peripheral model on the system bus
`default_nettype none
module bus_mem_model #(
    parameter int DELAY = 0
) (
    // Bus from the device
    input  wire logic        clk_sys,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_read,
    input  wire logic        mem_write,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        irq_ack,
    // Peripheral byte
    input  wire logic [7:0]  ack_byte,
    // Answer
    output logic             mem_valid,
    output logic [7:0]       mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [65536];
    logic [7:0] last = 8'h00;
    int         wait_n = 0;
    assign mem_valid = (mem_read || mem_write) && wait_n >= DELAY;
    // Idle bus shows no stale byte; peripheral answers acknowledge
    assign mem_rdata = !(mem_valid && mem_read) ? ~last : irq_ack ? ack_byte : mem[mem_addr];
    always @(posedge clk_sys) begin
        wait_n <= (mem_read || mem_write) && !mem_valid ? wait_n + 1 : 0;
        if (mem_valid && mem_read)
            last <= mem_rdata;
        if (mem_valid && mem_write)
            mem[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// >>> tb/tb_cpu_control_and_wide_arith_exec.sv
// Self-checking bench for the control and wide arithmetic unit
`default_nettype none
module tb_cpu_control_and_wide_arith_exec
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, rst_n = 1'b0, irq = 1'b0, load_en = 1'b0, phase_a = 1'b1;
    logic        base_en = 1'b0;
    logic [1:0]  load_sel = 2'h0;
    logic [15:0] load_data = 16'h0000;
    logic [7:0]  ack_byte = 8'h00;
    logic [15:0] mem_addr, program_counter, accum_pair, stack_pointer, pair_one, pair_two;
    logic [7:0]  mem_wdata, mem_rdata, vbase;
    logic [1:0]  irq_mode;
    logic        mem_read, mem_write, irq_ack, refresh_strobe, mem_valid, suspended;
    logic        sign_flag, zero_flag, half_carry_flag, parity_overflow_flag;
    logic        subtract_flag, carry_flag, int_enable_ff_main, int_enable_ff_shadow;
    logic [21:0] snap [16];
    logic [15:0] rq [$];
    int          tf [16];
    int          num_errors = 0, n_checks = 0, cyc = 0, nref = 0, r0;
    logic [15:0] pre [4] = '{16'h7001, 16'h7FFF, 16'h8FFF, 16'h8000};
    logic [7:0]  prog [12] = '{OP_IRQ_OFF, OP_IDLE, OP_ADD_BASE, OP_PREFIX, 8'h5A, OP_PREFIX,
                              OP_SBC_BASE, OP_PREFIX, OP_MODE1, OP_IRQ_ON, OP_IDLE, OP_SUSPEND};
    int          fa [8] = '{0, 1, 2, 3, 5, 7, 9, 10};
    int          gap [7] = '{4, 4, 11, 15, 15, 8, 4};
    wire  [5:0]  flg = {sign_flag, zero_flag, half_carry_flag, parity_overflow_flag,
                        subtract_flag, carry_flag};

    cpu_control_and_wide_arith_exec i_cpu_control_and_wide_arith_exec (
        .clk_sys, .rst_n, .mem_addr, .mem_read, .mem_write, .mem_wdata, .irq_ack,
        .refresh_strobe, .mem_valid, .mem_rdata, .maskable_irq_req(irq), .load_en,
        .load_sel, .load_data, .base_load_en(base_en), .base_load_data(8'h12),
        .program_counter, .pair_one, .pair_two, .accum_pair, .stack_pointer,
        .vector_base_reg(vbase), .sign_flag, .zero_flag, .half_carry_flag,
        .parity_overflow_flag, .subtract_flag, .carry_flag, .int_enable_ff_main,
        .int_enable_ff_shadow, .irq_mode, .suspended);
    bus_mem_model i_bus_mem_model (.clk_sys, .mem_addr, .mem_read, .mem_write,
        .mem_wdata, .irq_ack, .ack_byte, .mem_valid, .mem_rdata);

    always #5 clk_sys = ~clk_sys;
    // Log every transfer except acknowledge reads; fetch times and state only in the first program
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (refresh_strobe === 1'b1)
            nref <= nref + 1;
        if (mem_valid === 1'b1 && irq_ack === 1'b0) begin
            rq.push_back(mem_addr);
            if (phase_a && mem_read && mem_addr < 16) begin
                tf[mem_addr[3:0]] <= cyc;
                snap[mem_addr[3:0]] <= {flg, accum_pair};
            end
        end
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [21:0] exp, input logic [21:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Request held from reset on, so acceptance timing is exposed
    task automatic boot();
        rst_n <= 1'b0;
        irq <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("suspended", 22'h0, {21'h0, suspended});
        base_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            load_en <= 1'b1;
            load_sel <= 2'(i);
            load_data <= pre[i];
            @(posedge clk_sys);
        end
        load_en <= 1'b0;
        base_en <= 1'b0;
    endtask

    task automatic serve(input int n, input logic [15:0] e [5], input logic [15:0] ret,
                         input logic [15:0] sp, input logic [15:0] pc);
        do @(posedge clk_sys); while (irq_ack !== 1'b1);
        rq.delete();
        do @(posedge clk_sys); while (suspended !== 1'b1);
        r0 = nref;
        repeat (40) @(posedge clk_sys);
        for (int k = 0; k < n; k++)
            chk("bus order", 22'(e[k]), 22'(rq[k]));
        chk("return", 22'(ret), {6'h0, i_bus_mem_model.mem[16'h7FFF],
            i_bus_mem_model.mem[16'h7FFE]});
        chk("stack", 22'(sp), 22'(stack_pointer));
        chk("pc", 22'(pc), 22'(program_counter));
        chk("refresh", 22'h1, 22'(nref - r0 >= 8));
        chk("iffs", 22'h0, {20'h0, int_enable_ff_main, int_enable_ff_shadow});
    endtask

    initial begin
        foreach (prog[i])
            i_bus_mem_model.mem[i] = prog[i];
        i_bus_mem_model.mem[16'h0038] = OP_SUSPEND;
        i_bus_mem_model.mem[16'h0040] = OP_SUSPEND;
        i_bus_mem_model.mem[16'h1234] = 8'h40;
        i_bus_mem_model.mem[16'h1235] = 8'h00;
        boot();
        serve(3, '{16'h7FFF, 16'h7FFE, MODE1_TARGET, 16'h0, 16'h0}, 16'h000B, 16'h7FFE,
              16'h0039);
        for (int k = 0; k < 7; k++)
            chk("fetch gap", 22'(gap[k]), 22'(tf[fa[k+1]] - tf[fa[k]]));
        chk("add", {6'b001001, 16'h0000}, snap[3]);
        chk("adc", {6'b101100, 16'h8000}, snap[5]);
        chk("sbc", {6'b001110, 16'h0FFF}, snap[7]);
        chk("pair one", 22'(pre[0]), 22'(pair_one));
        chk("pair two", 22'(pre[1]), 22'(pair_two));
        chk("mode", 22'(IRQ_MODE_1), 22'(irq_mode));
        phase_a = 1'b0;
        i_bus_mem_model.mem[1] = OP_MODE2;
        i_bus_mem_model.mem[2] = OP_IRQ_ON;
        i_bus_mem_model.mem[3] = OP_IDLE;
        i_bus_mem_model.mem[4] = OP_SUSPEND;
        i_bus_mem_model.mem[0] = OP_PREFIX;
        ack_byte <= 8'h34;
        boot();
        serve(5, '{16'h7FFF, 16'h7FFE, 16'h1234, 16'h1235, 16'h0040}, 16'h0004, 16'h7FFE,
              16'h0041);
        chk("mode", 22'(IRQ_MODE_2), 22'(irq_mode));
        chk("base", 22'h12, 22'(vbase));
        i_bus_mem_model.mem[1] = OP_MODE0;
        i_bus_mem_model.mem[16'h7FFE] = 8'h00;
        ack_byte <= OP_SUSPEND;
        boot();
        serve(0, '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0}, 16'h0000, 16'h8000,
              16'h0004);
        chk("mode", 22'(IRQ_MODE_0), 22'(irq_mode));
        end_sim();
    end
endmodule
`default_nettype wire
